// ===== hw/irq_reset_ctrl.sv
// Interrupt mask gating, reset collection, reset pin stretching, cause status.
// Assumes registers reached over the internal serial register port; one clock.
`timescale 1ns/10ps

// Behaviour
// - Wake, hall and bus-wake flags interrupt only when their enable bit is one.
// - Overtemp, undervolt, overvolt, power-stage flags interrupt only when enabled.
// - Mask register is read/write and clears to zero on reset.
// - Overtemp reset disable bit set suppresses the overtemperature reset.
// - Five reset causes: overtemp, watchdog, undervolt, power-on, external pin.
// - Reset pin held low for stretch time after internal reset ends.
// - Overtemp reset sets its cause and clears registers except status.
// - Watchdog reset sets its cause and clears registers except status.
// - Undervolt pulls reset pin, sets cause, clears registers except status.
// - Power-on reset clears all registers, status holds only power-on bit.
// - After power-up the reset pin is held low for the stretch time.
// - External low on the reset pin sets the external cause bit.
// - Status bits clear on write one, ignore zero, otherwise stay set.
// - Bus wake from sleep sets bus-wake cause bit, cleared by writing one.
// - Wake-pin wake from sleep sets wake-pin cause bit, cleared by writing one.
// - Enabled event issues a pulse on the interrupt output if no enabled flag is already pending.
// - Flags set by events, cleared by writing one, cleared by reset.
module irq_reset_ctrl
	import irq_reset_pkg::*;
#(
	parameter int STRETCH = STRETCH_CYCLES
) (
	// Clock and power-on reset
	input  wire logic           clk,
	input  wire logic           rst_b,
	// Register port
	input  wire reg_req_t       req,
	output logic [7:0]          rdata_q,
	// Interrupt events, one-cycle pulses
	input  wire logic           ev_wake_pin,
	input  wire logic           ev_hall,
	input  wire logic           ev_bus_wake,
	input  wire logic           ev_overvolt,
	input  wire logic           ev_power_stage_fail,
	// Live conditions, asynchronous levels
	input  wire logic           cond_overtemp,
	input  wire logic           cond_undervolt_irq,
	// Internal reset sources, asynchronous levels
	input  wire int_reset_src_t reset_src,
	// Sleep wake-up causes, one-cycle pulses
	input  wire logic           wake_by_bus,
	input  wire logic           wake_by_pin,
	// Open-drain reset pin
	input  wire logic           rst_pin_in,
	output logic                rst_pin_out,
	output logic                rst_pin_oe_b,
	// Interrupt pulse, flag view and soft reset
	output logic                irq_pulse_q,
	output logic [7:0]          flags_q,
	output logic                soft_reset_q
);

	initial begin
		if (STRETCH < 1) begin
			$error("STRETCH must be at least one cycle");
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Synchronisers

	logic [2:0] src_s1_q;
	logic [2:0] src_s2_q;
	logic [1:0] cond_s1_q;
	logic [1:0] cond_s2_q;
	logic       pin_s1_q;
	logic       pin_s2_q;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			src_s1_q  <= 3'h0;
			src_s2_q  <= 3'h0;
			cond_s1_q <= 2'h0;
			cond_s2_q <= 2'h0;
			pin_s1_q  <= 1'b1;
			pin_s2_q  <= 1'b1;
		end else begin
			src_s1_q  <= {reset_src.overtemp, reset_src.watchdog, reset_src.undervolt};
			src_s2_q  <= src_s1_q;
			cond_s1_q <= {cond_overtemp, cond_undervolt_irq};
			cond_s2_q <= cond_s1_q;
			pin_s1_q  <= rst_pin_in;
			pin_s2_q  <= pin_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Mask register and reset source collection

	logic [7:0] mask_q;
	logic       ot_rst;
	logic       wd_rst;
	logic       uv_rst;
	logic       int_rst;

	assign ot_rst  = src_s2_q[2] && !mask_q[MSK_OT_RSTDIS];
	assign wd_rst  = src_s2_q[1];
	assign uv_rst  = src_s2_q[0];
	assign int_rst = ot_rst || wd_rst || uv_rst;

	logic wr_mask;
	logic wr_stat;
	assign wr_mask = req.wr && (req.addr == MASK_ADDR);
	assign wr_stat = req.wr && (req.addr == STATUS_ADDR);

	// Mask and flags cleared by power-on and internal resets, not by an external pin reset; status cleared by power-on reset only
	always_ff @(posedge clk) begin
		if (!rst_b || soft_reset_q) begin
			mask_q <= MASK_RESET;
		end else if (wr_mask) begin
			mask_q <= req.wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt flags, set wins over clear

	logic [NUM_FLAGS-1:0] ev;
	logic [NUM_FLAGS-1:0] live;
	logic [NUM_FLAGS-1:0] en;
	logic [NUM_FLAGS-1:0] fl_q;
	logic                 wr_flags;

	assign wr_flags = req.wr && (req.addr == (MASK_ADDR + 8'h01));
	assign ev   = {ev_power_stage_fail, ev_overvolt, cond_s2_q[0], cond_s2_q[1],
	               ev_bus_wake, ev_hall, ev_wake_pin};
	assign live = {2'b00, cond_s2_q[0], cond_s2_q[1], 3'b000};
	assign en   = {mask_q[MSK_PSF], mask_q[MSK_OV], mask_q[MSK_UV], mask_q[MSK_OT],
	               mask_q[MSK_BUS_WAKE], mask_q[MSK_HALL], mask_q[MSK_WAKE_PIN]};

	always_ff @(posedge clk) begin
		if (!rst_b || soft_reset_q) begin
			fl_q <= '0;
		end else begin
			fl_q <= ev | live | (fl_q & ~(wr_flags ? req.wdata[NUM_FLAGS-1:0]
			                                        : {NUM_FLAGS{1'b0}}));
		end
	end

	assign flags_q = {1'b0, fl_q};

	// Pulse when an enabled flag becomes pending while no enabled flag was pending
	logic                 pend;
	logic                 pend_q;
	assign pend = |(fl_q & en);

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pend_q      <= 1'b0;
			irq_pulse_q <= 1'b0;
		end else begin
			pend_q      <= pend;
			irq_pulse_q <= pend && !pend_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reset stretch and pin drive

	localparam int CW = $clog2(STRETCH + 1);
	logic [CW-1:0] str_q;
	logic          drive_low;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			str_q <= CW'(STRETCH);
		end else if (int_rst) begin
			str_q <= CW'(STRETCH);
		end else if (str_q != '0) begin
			str_q <= str_q - CW'(1);
		end
	end

	assign drive_low    = int_rst || (str_q != '0);
	assign rst_pin_out  = 1'b0;
	assign rst_pin_oe_b = !drive_low;

	// External reset is a low pin not caused by our own drive
	// Drive history covers the two synchroniser stages of the pin
	logic [1:0] drv_hist_q;
	logic       ext_rst;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			drv_hist_q <= 2'h3;
		end else begin
			drv_hist_q <= {drv_hist_q[0], drive_low};
		end
	end

	assign ext_rst = !pin_s2_q && !drive_low && (drv_hist_q == 2'h0);

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			soft_reset_q <= 1'b0;
		end else begin
			soft_reset_q <= int_rst;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reset cause status, write one to clear, set wins

	logic [7:0] stat_q;
	logic [7:0] stat_set;
	logic [7:0] stat_clr;

	always_comb begin
		stat_set              = 8'h00;
		stat_set[ST_OT_RST]   = ot_rst;
		stat_set[ST_WDOG]     = wd_rst;
		stat_set[ST_UV_RST]   = uv_rst;
		stat_set[ST_EXT_PIN]  = ext_rst;
		stat_set[ST_BUS_WAKE] = wake_by_bus;
		stat_set[ST_WAKE_PIN] = wake_by_pin;
		stat_clr              = wr_stat ? req.wdata : 8'h00;
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			stat_q <= STATUS_POR_VAL;
		end else begin
			stat_q <= stat_set | (stat_q & ~stat_clr);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rdata_q <= 8'h00;
		end else if (req.rd) begin
			case (req.addr)
				MASK_ADDR:           rdata_q <= mask_q;
				MASK_ADDR + 8'h01:   rdata_q <= {1'b0, fl_q};
				STATUS_ADDR:         rdata_q <= stat_q;
				default:             rdata_q <= 8'h00;
			endcase
		end
	end

endmodule : irq_reset_ctrl

// ===== hw/irq_reset_pkg.sv
// Constants and carrier types for the interrupt mask and reset status block.
// Assumes a single 50 MHz clock domain.
package irq_reset_pkg;

	localparam logic [7:0] MASK_ADDR      = 8'h09;
	localparam logic [7:0] STATUS_ADDR    = 8'h0D;
	localparam logic [7:0] MASK_RESET     = 8'h00;
	localparam logic [7:0] STATUS_POR_VAL = 8'h80;

	// Mask register bit positions
	localparam int MSK_WAKE_PIN  = 0;
	localparam int MSK_HALL      = 1;
	localparam int MSK_BUS_WAKE  = 2;
	localparam int MSK_OT_RSTDIS = 3;
	localparam int MSK_OT        = 4;
	localparam int MSK_UV        = 5;
	localparam int MSK_OV        = 6;
	localparam int MSK_PSF       = 7;

	// Status register bit positions
	localparam int ST_WAKE_PIN = 0;
	localparam int ST_BUS_WAKE = 1;
	localparam int ST_UV_RST   = 3;
	localparam int ST_OT_RST   = 4;
	localparam int ST_WDOG     = 5;
	localparam int ST_EXT_PIN  = 6;
	localparam int ST_POR      = 7;

	// Reset stretch time
	localparam int CLK_HZ          = 50_000_000;
	localparam int STRETCH_NS      = 1_250_000;
	localparam int STRETCH_CYCLES  = (CLK_HZ / 1_000_000) * STRETCH_NS / 1000;

	// Number of interrupt flags
	localparam int NUM_FLAGS = 7;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic       overtemp;
		logic       watchdog;
		logic       undervolt;
	} int_reset_src_t;

endpackage : irq_reset_pkg

// ===== verification/irq_reset_props.sv
// Port checker for the interrupt mask and reset status block.
// Assumes one clock; bound to every irq_reset_ctrl instance.
`timescale 1ns/10ps
module irq_reset_props
	import irq_reset_pkg::*;
#(
	parameter int STRETCH = 8
) (
	// Clock and reset
	input wire logic           clk,
	input wire logic           rst_b,
	// Watched ports
	input wire reg_req_t       req,
	input wire logic [7:0]     rdata_q,
	input wire int_reset_src_t reset_src,
	input wire logic           rst_pin_oe_b,
	input wire logic           irq_pulse_q,
	input wire logic [7:0]     flags_q,
	input wire logic           soft_reset_q
);
	int low_q;
	always_ff @(posedge clk) low_q <= (!rst_b || rst_pin_oe_b) ? 0 : low_q + 1;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	AST_PULSE: assert property (irq_pulse_q |=> !irq_pulse_q)
		else $error("irq pulse too long");
	AST_STRETCH: assert property ($rose(rst_pin_oe_b) |-> low_q >= STRETCH)
		else $error("reset pin released early");
	AST_SRC_DRIVE: assert property ($rose(reset_src.watchdog) |-> ##[1:4] !rst_pin_oe_b)
		else $error("reset pin not driven");
	AST_SOFT_PIN: assert property (soft_reset_q |-> !rst_pin_oe_b)
		else $error("soft reset without pin low");
	AST_SOFT_CLR: assert property (soft_reset_q |=> flags_q == 8'h00)
		else $error("flags survive reset");
	AST_W0_KEEP: assert property (req.wr && req.addr == 8'h0A && !req.wdata[0] && flags_q[0]
		&& !soft_reset_q && reset_src == '0 |=> flags_q[0])
		else $error("flag lost on zero write");
	AST_MASK_RW: assert property (req.wr && req.addr == MASK_ADDR ##2 req.rd
		&& req.addr == MASK_ADDR |=> rdata_q == $past(req.wdata, 3))
		else $error("mask readback wrong");
	AST_IRQ_CAUSE: assert property (irq_pulse_q |-> flags_q != 8'h00)
		else $error("irq without pending flag");
endmodule : irq_reset_props
bind irq_reset_ctrl irq_reset_props #(.STRETCH(STRETCH)) u_props (.clk(clk), .rst_b(rst_b),
	.req(req), .rdata_q(rdata_q), .reset_src(reset_src), .rst_pin_oe_b(rst_pin_oe_b),
	.irq_pulse_q(irq_pulse_q), .flags_q(flags_q), .soft_reset_q(soft_reset_q));

// ===== verification/mcu_model.sv
// Controller side of the register port: single-cycle strobes.
// Assumes tasks are called right after a rising clock edge.
`timescale 1ns/10ps
module mcu_model
	import irq_reset_pkg::*;
(
	// Clock
	input wire logic       clk,
	// Register port
	output reg_req_t       req,
	input wire logic [7:0] rdata_q
);
	initial req = '0;
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		req <= '{1'b1, 1'b0, a, v};
		@(posedge clk);
		req <= '0;
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk);
		req <= '0;
		@(posedge clk);
		v = rdata_q;
	endtask : rd
endmodule : mcu_model

// ===== verification/test_irq_reset_ctrl.sv
// Self-checking bench for irq_reset_ctrl with a short stretch count.
// Assumes mcu_model drives the register port.
`timescale 1ns/10ps
module test_irq_reset_ctrl;
	import irq_reset_pkg::*;
	localparam int ST = 8;
	localparam logic [7:0] CAUSE [3] = '{8'h08, 8'h20, 8'h10};
	logic clk = 1'b0, rst_b = 1'b0, ext_b = 1'b1, wb = 1'b0, wp = 1'b0, oe_b, po, irq, sr;
	logic [6:0] ev = '0;
	int_reset_src_t src = '0;
	reg_req_t req;
	logic [7:0] rdata_q, flags_q, d;
	int n_errors = 0, cmp_count = 0, n_irq = 0;
	always #10 clk = ~clk;
	always @(posedge clk) n_irq <= n_irq + int'(irq === 1'b1);
	mcu_model mcu (.clk(clk), .req(req), .rdata_q(rdata_q));
	irq_reset_ctrl #(.STRETCH(ST)) dut (.clk(clk), .rst_b(rst_b), .req(req), .rdata_q(rdata_q),
		.ev_wake_pin(ev[0]), .ev_hall(ev[1]), .ev_bus_wake(ev[2]), .cond_overtemp(ev[3]),
		.cond_undervolt_irq(ev[4]), .ev_overvolt(ev[5]), .ev_power_stage_fail(ev[6]),
		.reset_src(src), .wake_by_bus(wb), .wake_by_pin(wp), .rst_pin_in(ext_b & (oe_b | po)),
		.rst_pin_out(po), .rst_pin_oe_b(oe_b), .irq_pulse_q(irq), .flags_q(flags_q),
		.soft_reset_q(sr));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		mcu.rd(a, d);
		check(d, exp);
	endtask : rdchk
	task automatic hold_low;
		int n = 0;
		while (oe_b !== 1'b1 && n < 200) begin
			@(posedge clk);
			n++;
		end
		check(8'(n >= ST), 8'h01);
	endtask : hold_low
	task automatic t_por;
		check(8'(oe_b), 8'h00);
		hold_low;
		rdchk(STATUS_ADDR, STATUS_POR_VAL);
		rdchk(MASK_ADDR, MASK_RESET);
		mcu.wr(STATUS_ADDR, 8'h00);
		rdchk(STATUS_ADDR, 8'h80);
		mcu.wr(STATUS_ADDR, 8'h80);
		rdchk(STATUS_ADDR, 8'h00);
		mcu.wr(MASK_ADDR, 8'hA5);
		rdchk(MASK_ADDR, 8'hA5);
		$display("por test done");
	endtask : t_por
	task automatic pulse(input int k);
		ev[k] <= 1'b1;
		@(posedge clk);
		ev <= '0;
		repeat (6) @(posedge clk);
	endtask : pulse
	task automatic t_irq;
		int base;
		for (int k = 0; k < 7; k++) begin
			mcu.wr(MASK_ADDR, 8'h00);
			base = n_irq;
			pulse(k);
			mcu.wr(8'h0A, 8'h00);
			check(8'(flags_q[k]), 8'h01);
			check(8'(n_irq - base), 8'h00);
			mcu.wr(8'h0A, 8'h01 << k);
			check(flags_q, 8'h00);
			mcu.wr(MASK_ADDR, 8'h01 << (k < 3 ? k : k + 1));
			pulse(k);
			check(8'(n_irq - base), 8'h01);
			mcu.wr(8'h0A, 8'h01 << k);
		end
		$display("irq test done");
	endtask : t_irq
	task automatic t_reset;
		for (int k = 0; k < 3; k++) begin
			mcu.wr(MASK_ADDR, 8'h17);
			src <= int_reset_src_t'(3'b001 << k);
			repeat (5) @(posedge clk);
			check(8'(oe_b), 8'h00);
			src <= '0;
			@(posedge clk);
			hold_low;
			rdchk(MASK_ADDR, 8'h00);
			rdchk(STATUS_ADDR, CAUSE[k]);
			mcu.wr(STATUS_ADDR, CAUSE[k]);
		end
		mcu.wr(MASK_ADDR, 8'h08);
		src <= 3'b100;
		repeat (5) @(posedge clk);
		check(8'(oe_b), 8'h01);
		src <= '0;
		rdchk(STATUS_ADDR, 8'h00);
		$display("reset test done");
	endtask : t_reset
	task automatic t_cause;
		ext_b <= 1'b0;
		repeat (3) @(posedge clk);
		ext_b <= 1'b1;
		repeat (3) @(posedge clk);
		check(8'(oe_b), 8'h01);
		rdchk(STATUS_ADDR, 8'h40);
		mcu.wr(STATUS_ADDR, 8'h40);
		wb <= 1'b1;
		@(posedge clk);
		wb <= 1'b0;
		wp <= 1'b1;
		@(posedge clk);
		wp <= 1'b0;
		rdchk(STATUS_ADDR, 8'h03);
		$display("cause test done");
	endtask : t_cause
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : test_done
	initial begin
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		t_por;
		t_irq;
		t_reset;
		t_cause;
		rst_b <= 1'b0;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		t_por;
		test_done;
	end
	initial begin
		#500us;
		n_errors++;
		test_done;
	end
endmodule : test_irq_reset_ctrl
